// [hdl/aas_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing factors of the ADC sequencer.
// Assumes: APB byte address = 4 x register index; 8-bit registers in the low byte, 10-bit thresholds in bits 9:0.
// Notes: Definitions only.
`ifndef AAS_CFG_SVH
`define AAS_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define AAS_IDX_DATA_LAST 8'h1F
`define AAS_IDX_THR_A_UP 8'h20
`define AAS_IDX_THR_A_LO 8'h21
`define AAS_IDX_THR_B_UP 8'h22
`define AAS_IDX_THR_B_LO 8'h23
`define AAS_IDX_FLAGS 8'h24
`define AAS_IDX_IRQC 8'h25
`define AAS_IDX_CTL1 8'hFC
`define AAS_IDX_CTL2 8'hFD

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AAS_CTL1_FIRST_MSB 7
`define AAS_CTL1_FIRST_LSB 4
`define AAS_CTL1_PAIR_MSB 3
`define AAS_CTL1_PAIR_LSB 0
`define AAS_CTL2_DIV_MSB 7
`define AAS_CTL2_DIV_LSB 5
`define AAS_CTL2_REPEAT 4
`define AAS_CTL2_EXT_MASK 3
`define AAS_CTL2_TMR_EN 2
`define AAS_CTL2_BIAS 1
`define AAS_CTL2_GO 0
`define AAS_IRQC_DONE 7
`define AAS_IRQC_ALARM 6
`define AAS_IRQC_SEQ_MASK 5
`define AAS_IRQC_WD_MASK 4
`define AAS_IRQC_LVL_MSB 2
`define AAS_IRQC_LVL_LSB 0

// ----------------------------------------------------------------
// Reset values, timing factors and last scan channel
// ----------------------------------------------------------------
`define AAS_CTL1_RST 8'h00
`define AAS_CTL2_RST 6'h00
`define AAS_THR_UP_RST 10'h3FF
`define AAS_THR_LO_RST 10'h000
`define AAS_CLK_DIV2 2
`define AAS_SAMPLE_MULT 8
`define AAS_CONV_MULT 28
`define AAS_LAST_CHANNEL 4'hF

`endif

// [hdl/aas_pkg.sv]
// Purpose: Types shared by the ADC sequencer and its bench.
// Assumes: Constants live in aas_cfg.svh.
// Notes: Nothing here is imported; use aas_pkg::name.
package aas_pkg;

	// APB request as driven by the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} aas_apb_req_type;

	// Sequencer states
	typedef enum logic {
		AAS_IDLE,
		AAS_RUN
	} aas_seq_state_type;

endpackage

// [hdl/aas_top.sv]
// Purpose: ADC autoscan sequencer, trigger logic, analog watchdogs, result store, APB slave.
// Assumes: Converter result valid on conv_result_in when the conversion slot ends.
// Notes: Single clock mclk_in; external trigger pin is synchronised.
//
// Implementation choice: the APB interface to the registers.
`include "aas_cfg.svh"

// Summary of operation
// (R1) Analog clock is system clock divided by selected prescaler then by two.
// (R2) Sample lasts 2*div*8 system clocks; conversion lasts 2*div*28 system clocks.
// (R3) Repeat bit one selects continuous mode, zero selects single mode.
// (R4) Scan starts at first channel, increments after each conversion, ends at 15.
// (R5) Go flag from software or trigger converts channels, storing each result.
// (R6) Single mode: after channel 15, clear go, flag done, go idle.
// (R7) Continuous mode: after channel 15 restart at first until go cleared.
// (R8) Every channel 15 completion raises the sequence done request.
// (R9) New result overwrites channel data; no buffering, no overrun flag.
// (R10) External and timer triggers, each masked, are ORed together.
// (R11) Software should enable only one trigger source at once.
// (R12) Accepted trigger sets go; later pulses in continuous mode do nothing.
// (R13) Triggers arriving while go is set are ignored.
// (R14) Triggers stay low two clocks; single-mode spacing exceeds a group.
// (R15) External trigger sets go even with bias disabled.
// (R16) Watchdogs A and B watch adjacent channels chosen by pair select.
// (R17) Result at or above upper, or below lower, raises watchdog request.
// (R18) Four thresholds; top four flag bits tell which bound and channel fired.
// (R19) Flags reset to zero, set on alarm, cleared when alarm pending cleared.
// (R20) Software enables bias ten microseconds before first conversion.
// (R21) Bias resets off and is forced off in halt.
// (R22) Two maskable requests, fixed relative priority, programmable level up to 7.
// (R23) Simultaneous requests: watchdog served first, sequence done stays pending.
// (R24) Software writing one to a pending flag raises its request.
// (R25) Result bits 9:2 in high register, 1:0 in low bits 7:6.
module aas_top (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire aas_pkg::aas_apb_req_type apb_req_in,
	output logic [31:0] apb_prdata_out,
	output logic apb_pready_out,
	output logic apb_pslverr_out,
	input wire logic ext_trigger_in,
	input wire logic timer_trigger_in,
	input wire logic halt_in,
	input wire logic [9:0] conv_result_in,
	output logic [3:0] mux_channel_out,
	output logic sample_out,
	output logic analog_clock_out,
	output logic bias_enable_out,
	output logic irq_wd_out,
	output logic irq_seq_out,
	output logic [2:0] irq_level_out
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic [7:0] ctl1_q;
	logic [5:0] ctl2_q;
	logic go_q, bias_q;
	logic [9:0] thr_q [4];
	logic [9:0] data_q [16];
	logic [3:0] flags_q;
	logic done_q, alarm_q, mask_seq_q, mask_wd_q;
	logic [2:0] lvl_q;
	logic ext_s1_q, ext_s2_q, ext_s3_q, tmr_prev_q;
	aas_pkg::aas_seq_state_type state_q, state_d;
	logic [3:0] chan_q, chan_d;
	logic [8:0] cnt_q, cnt_d;
	logic [2:0] pre_q;
	logic sample_q, aclk_q, irq_wd_q, irq_seq_q;
	logic [3:0] fire;

	// Register index match; used by the CTL1, CTL2 and IRQC write decoders
	function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] want);
		idx_is = (idx == want);
	endfunction

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire [7:0] idx = apb_req_in.paddr[9:2];
	wire acc = apb_req_in.psel & apb_req_in.penable;
	wire aligned = (apb_req_in.paddr[11:10] == 2'h0) && (apb_req_in.paddr[1:0] == 2'h0);
	wire mapped = aligned && (idx <= `AAS_IDX_IRQC || idx_is(idx, `AAS_IDX_CTL1)
		|| idx_is(idx, `AAS_IDX_CTL2));
	wire wr = acc & pready_q & apb_req_in.pwrite & mapped;
	wire [7:0] wd = apb_req_in.pwdata[7:0];
	wire wr_ctl1 = wr & idx_is(idx, `AAS_IDX_CTL1);
	wire wr_ctl2 = wr & idx_is(idx, `AAS_IDX_CTL2);
	wire wr_irqc = wr & idx_is(idx, `AAS_IDX_IRQC);

	// Read selection; data pairs split 9:2 high, 1:0 at 7:6 low
	wire [3:0] rd_ch = idx[4:1];
	wire [7:0] rd_data = idx[0] ? {data_q[rd_ch][1:0], 6'h00} : data_q[rd_ch][9:2]; // R25
	wire [7:0] rd_ctl2 = {ctl2_q, bias_q, go_q};
	wire [7:0] rd_irqc = {done_q, alarm_q, mask_seq_q, mask_wd_q, 1'b0, lvl_q};
	wire [9:0] rd_thr = thr_q[idx[1:0]];
	wire [31:0] rd_word = (idx <= `AAS_IDX_DATA_LAST) ? {24'h000000, rd_data} :
		(idx <= `AAS_IDX_THR_B_LO) ? {22'h0, rd_thr} :
		idx_is(idx, `AAS_IDX_FLAGS) ? {24'h000000, flags_q, 4'h0} : // R18
		idx_is(idx, `AAS_IDX_IRQC) ? {24'h000000, rd_irqc} :
		idx_is(idx, `AAS_IDX_CTL1) ? {24'h000000, ctl1_q} :
		idx_is(idx, `AAS_IDX_CTL2) ? {24'h000000, rd_ctl2} : 32'h00000000;

	// Answer one cycle into the access phase so every bus output is a flop
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= acc & ~pready_q;
			pslverr_q <= acc & ~pready_q & ~mapped;
			prdata_q <= (acc & ~pready_q & ~apb_req_in.pwrite) ? rd_word : 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Triggers
	// ----------------------------------------------------------------
	// Pin passes two flops; the third only feeds the falling-edge detector
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ext_s1_q <= 1'b1;
			ext_s2_q <= 1'b1;
			ext_s3_q <= 1'b1;
			tmr_prev_q <= 1'b1;
		end else begin
			ext_s1_q <= ext_trigger_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			tmr_prev_q <= timer_trigger_in;
		end
	end

	wire ext_fall = ext_s3_q & ~ext_s2_q;
	wire tmr_fall = tmr_prev_q & ~timer_trigger_in;
	// Gated sources ORed; bias state plays no part here
	wire trig_any = (ext_fall & ctl2_q[`AAS_CTL2_EXT_MASK - 2]) // R10 R15
		| (tmr_fall & ctl2_q[`AAS_CTL2_TMR_EN - 2]); // R10
	wire trig_acc = trig_any & ~go_q; // R12 R13

	// ----------------------------------------------------------------
	// Timing of one conversion slot
	// ----------------------------------------------------------------
	wire [2:0] div_sel = ctl2_q[`AAS_CTL2_DIV_MSB - 2:`AAS_CTL2_DIV_LSB - 2];
	// A zero setting would give a zero-length slot, so it behaves as one
	wire [2:0] div_eff = (div_sel == 3'h0) ? 3'h1 : div_sel;
	wire [8:0] samp_len = 9'(`AAS_CLK_DIV2 * `AAS_SAMPLE_MULT * div_eff); // R2
	wire [8:0] conv_len = 9'(`AAS_CLK_DIV2 * `AAS_CONV_MULT * div_eff); // R2
	wire slot_last = (cnt_q == conv_len - 9'h001);
	wire repeat_on = ctl2_q[`AAS_CTL2_REPEAT - 2];
	wire [3:0] first_ch = ctl1_q[`AAS_CTL1_FIRST_MSB:`AAS_CTL1_FIRST_LSB];
	wire conv_end = (state_q == aas_pkg::AAS_RUN) & go_q & slot_last;
	wire end15 = conv_end & (chan_q == `AAS_LAST_CHANNEL);
	wire hw_stop = end15 & ~repeat_on; // R6

	// ----------------------------------------------------------------
	// Sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		chan_d = chan_q;
		cnt_d = cnt_q;
		case (state_q)
			aas_pkg::AAS_IDLE: begin
				if (go_q) begin
					state_d = aas_pkg::AAS_RUN;
					chan_d = first_ch; // R4 R5
					cnt_d = 9'h000;
				end
			end
			aas_pkg::AAS_RUN: begin
				if (!go_q) begin
					state_d = aas_pkg::AAS_IDLE; // R7
				end else if (slot_last) begin
					cnt_d = 9'h000;
					if (chan_q != `AAS_LAST_CHANNEL) begin
						chan_d = chan_q + 4'h1; // R4
					end else if (repeat_on) begin
						chan_d = first_ch; // R3 R7
					end else begin
						state_d = aas_pkg::AAS_IDLE; // R3 R6
					end
				end else begin
					cnt_d = cnt_q + 9'h001;
				end
			end
			default: begin
				state_d = aas_pkg::AAS_IDLE;
			end
		endcase
	end

	// Sequencer registers and converter-facing strobes
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q <= aas_pkg::AAS_IDLE;
			chan_q <= 4'h0;
			cnt_q <= 9'h000;
			sample_q <= 1'b0;
		end else begin
			state_q <= state_d;
			chan_q <= chan_d;
			cnt_q <= cnt_d;
			sample_q <= (state_d == aas_pkg::AAS_RUN) && (cnt_d < samp_len); // R2
		end
	end

	// Analog clock: prescaler then toggle, so period is 2 x div_eff
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pre_q <= 3'h0;
			aclk_q <= 1'b0;
		end else if (pre_q >= div_eff - 3'h1) begin
			pre_q <= 3'h0;
			aclk_q <= ~aclk_q; // R1
		end else begin
			pre_q <= pre_q + 3'h1; // R1
		end
	end

	// ----------------------------------------------------------------
	// Result store: plain overwrite, the old value is lost
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 16; i++) begin : g_data
		always_ff @(posedge mclk_in or posedge sys_rst_in) begin
			if (sys_rst_in) begin
				data_q[i] <= 10'h000;
			end else if (conv_end && chan_q == 4'(i)) begin
				data_q[i] <= conv_result_in; // R5 R9
			end
		end
	end

	// ----------------------------------------------------------------
	// Analog watchdogs A (g=0) and B (g=1)
	// ----------------------------------------------------------------
	wire [3:0] pair_sel = ctl1_q[`AAS_CTL1_PAIR_MSB:`AAS_CTL1_PAIR_LSB];
	for (genvar g = 0; g < 2; g++) begin : g_wd
		wire [3:0] wd_ch = pair_sel + 4'(g); // R16
		wire hit = conv_end & (chan_q == wd_ch);
		assign fire[3 - 2 * g] = hit & (conv_result_in >= thr_q[2 * g]); // R17
		assign fire[2 - 2 * g] = hit & (conv_result_in < thr_q[2 * g + 1]); // R17
	end

	// Alarm clear by software also wipes the flags; a new alarm wins
	wire alarm_clr = wr_irqc & ~wd[`AAS_IRQC_ALARM] & alarm_q;
	wire [3:0] flags_d = fire | (alarm_clr ? 4'h0 : flags_q); // R18 R19

	// ----------------------------------------------------------------
	// Control, threshold and interrupt registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctl1_q <= `AAS_CTL1_RST;
			ctl2_q <= `AAS_CTL2_RST;
		end else begin
			if (wr_ctl1) begin
				ctl1_q <= wd;
			end
			if (wr_ctl2) begin
				ctl2_q <= wd[7:2];
			end
		end
	end

	// Go: software or trigger set wins over any clear in the same cycle
	wire go_set = trig_acc | (wr_ctl2 & wd[`AAS_CTL2_GO]); // R5 R12
	wire go_clr = hw_stop | (wr_ctl2 & ~wd[`AAS_CTL2_GO]); // R6 R7

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			go_q <= 1'b0;
			bias_q <= 1'b0; // R21
			flags_q <= 4'h0; // R19
		end else begin
			go_q <= go_set | (go_q & ~go_clr);
			bias_q <= halt_in ? 1'b0 : (wr_ctl2 ? wd[`AAS_CTL2_BIAS] : bias_q); // R21
			flags_q <= flags_d;
		end
	end

	for (genvar t = 0; t < 4; t++) begin : g_thr
		always_ff @(posedge mclk_in or posedge sys_rst_in) begin
			if (sys_rst_in) begin
				thr_q[t] <= (t % 2 == 1) ? `AAS_THR_LO_RST : `AAS_THR_UP_RST;
			end else if (wr && idx == `AAS_IDX_THR_A_UP + 8'(t)) begin
				thr_q[t] <= apb_req_in.pwdata[9:0];
			end
		end
	end

	// Pending flags: hardware set wins, software may set or clear
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			done_q <= 1'b0;
			alarm_q <= 1'b0;
			mask_seq_q <= 1'b0;
			mask_wd_q <= 1'b0;
			lvl_q <= 3'h0;
		end else begin
			done_q <= end15 | (wr_irqc ? wd[`AAS_IRQC_DONE] : done_q); // R8 R24
			alarm_q <= (|fire) | (wr_irqc ? wd[`AAS_IRQC_ALARM] : alarm_q); // R17 R24
			if (wr_irqc) begin
				mask_seq_q <= wd[`AAS_IRQC_SEQ_MASK];
				mask_wd_q <= wd[`AAS_IRQC_WD_MASK];
				lvl_q <= wd[`AAS_IRQC_LVL_MSB:`AAS_IRQC_LVL_LSB]; // R22
			end
		end
	end

	// Watchdog request outranks sequence done, which stays pending
	wire wd_req = alarm_q & mask_wd_q;
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_wd_q <= 1'b0;
			irq_seq_q <= 1'b0;
		end else begin
			irq_wd_q <= wd_req; // R22
			irq_seq_q <= done_q & mask_seq_q & ~wd_req; // R22 R23
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign apb_prdata_out = prdata_q;
	assign apb_pready_out = pready_q;
	assign apb_pslverr_out = pslverr_q;
	assign mux_channel_out = chan_q;
	assign sample_out = sample_q;
	assign analog_clock_out = aclk_q;
	assign bias_enable_out = bias_q;
	assign irq_wd_out = irq_wd_q;
	assign irq_seq_out = irq_seq_q;
	assign irq_level_out = lvl_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	property p_single_stop;
		end15 && !repeat_on && !go_set |=> !go_q && done_q && state_q == aas_pkg::AAS_IDLE;
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("single stop failed"); // R6

	property p_cont_wrap;
		end15 && repeat_on && !go_clr |=> chan_q == $past(first_ch) && go_q;
	endproperty
	a_cont_wrap: assert property (p_cont_wrap) else $error("continuous wrap failed"); // R7

	property p_done_every;
		end15 |=> done_q;
	endproperty
	a_done_every: assert property (p_done_every) else $error("done not raised"); // R8

	property p_start_first;
		state_q == aas_pkg::AAS_IDLE && go_q |=> state_q == aas_pkg::AAS_RUN
			&& chan_q == $past(first_ch) && cnt_q == 9'h000;
	endproperty
	a_start_first: assert property (p_start_first) else $error("bad start channel"); // R4

	property p_slot_len;
		state_q == aas_pkg::AAS_RUN && go_q && cnt_q == 9'h000 && div_sel == 3'h1
			&& $stable(div_sel) ##1 go_q [*8] |-> cnt_q == 9'h008;
	endproperty
	a_slot_len: assert property (p_slot_len) else $error("slot counter jump"); // R2

	property p_ignore_busy;
		go_q && trig_any && !wr_ctl2 && !hw_stop |=> go_q;
	endproperty
	a_ignore_busy: assert property (p_ignore_busy) else $error("trigger disturbed go"); // R13

	property p_flag_set;
		|fire |=> alarm_q && ((flags_q & $past(fire)) == $past(fire));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("alarm flag missing"); // R17

	property p_flag_clr;
		alarm_clr && !(|fire) |=> flags_q == 4'h0;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared"); // R19

	property p_halt_bias;
		halt_in |=> !bias_enable_out;
	endproperty
	a_halt_bias: assert property (p_halt_bias) else $error("bias on in halt"); // R21

	property p_prio;
		irq_wd_out |-> !irq_seq_out;
	endproperty
	a_prio: assert property (p_prio) else $error("priority broken"); // R23

	property p_store;
		conv_end |=> data_q[$past(chan_q)] == $past(conv_result_in);
	endproperty
	a_store: assert property (p_store) else $error("result not stored"); // R9

endmodule // aas_top

// [dv/aas_conv_model.sv]
// Purpose: Behavioural converter and multiplexer on the far side of the sequencer.
// Assumes: Result is read by the sequencer in the last cycle of each slot.
// Notes: Result is a known function of channel and base, so the bench can predict it.
module aas_conv_model (
	input wire logic clk_in,
	input wire logic [3:0] channel_in,
	input wire logic bias_in,
	input wire logic [9:0] base_in,
	output logic [9:0] result_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Conversion result
	// ----------------------------------------------------------------
	initial result_out = 10'h2AA;

	// Unpowered, the output toggles every cycle so a stale value never passes for data
	always @(posedge clk_in) begin
		if (bias_in) begin
			result_out <= base_in ^ {channel_in, channel_in, 2'b01};
		end else begin
			result_out <= ~result_out;
		end
	end
endmodule // aas_conv_model

// [dv/aas_top_tb_top.sv]
// Purpose: Self-checking bench for the ADC autoscan sequencer.
// Assumes: APB slave answers after one wait state; converter model on the far side.
// Notes: Divider kept at 1 or 2 so that scans stay short.
`include "aas_cfg.svh"
module aas_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	aas_pkg::aas_apb_req_type req = '0;
	logic [31:0] prdata;
	logic pready, pslverr, last_err, sample, aclk, bias, irq_wd, irq_seq;
	logic ext_trg = 1'b1;
	logic tmr_trg = 1'b1;
	logic halt = 1'b0;
	logic [3:0] mux_ch;
	logic [2:0] irq_lvl;
	logic [9:0] result;
	logic [9:0] base = 10'h155;
	int num_errors = 0;
	int n_compared = 0;

	always #5 mclk_in = ~mclk_in;

	aas_top aas_top_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .apb_req_in(req),
		.apb_prdata_out(prdata), .apb_pready_out(pready), .apb_pslverr_out(pslverr),
		.ext_trigger_in(ext_trg), .timer_trigger_in(tmr_trg), .halt_in(halt),
		.conv_result_in(result), .mux_channel_out(mux_ch), .sample_out(sample),
		.analog_clock_out(aclk), .bias_enable_out(bias), .irq_wd_out(irq_wd),
		.irq_seq_out(irq_seq), .irq_level_out(irq_lvl));

	aas_conv_model aas_conv_model_i (.clk_in(mclk_in), .channel_in(mux_ch),
		.bias_in(bias), .base_in(base), .result_out(result));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held from setup until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
			output logic [31:0] r);
		int n = 0;
		@(posedge mclk_in);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'b00, idx, 2'b00}, pwdata: d};
		@(posedge mclk_in);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
		end
		r = prdata;
		last_err = pslverr;
		req <= '0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, idx, d, r);
	endtask

	task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, idx, 32'h0, r);
		chk(r, exp);
	endtask

	// Bounded poll of one register bit; the bound stands in for a hang
	task automatic poll(input logic [7:0] idx, input int b, input logic v);
		logic [31:0] r;
		int n = 0;
		do begin
			apb(1'b0, idx, 32'h0, r);
			n++;
		end while (r[b] !== v && n < 300);
		chk({31'h0, r[b]}, {31'h0, v});
	endtask

	// Result split across the pair: high holds bits 9:2, low holds 1:0 at 7:6
	task automatic data(input logic [3:0] c, input logic [9:0] b);
		logic [9:0] v;
		v = b ^ {c, c, 2'b01};
		rc({3'b000, c, 1'b0}, {24'h0, v[9:2]});
		rc({3'b000, c, 1'b1}, {24'h0, v[1:0], 6'h00});
	endtask

	// Low for three cycles, longer than the two-cycle minimum
	task automatic pulse(input logic ext);
		@(posedge mclk_in);
		if (ext) begin
			ext_trg <= 1'b0;
		end else begin
			tmr_trg <= 1'b0;
		end
		repeat (3) @(posedge mclk_in);
		ext_trg <= 1'b1;
		tmr_trg <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rc(`AAS_IDX_CTL2, 32'h0);
		chk({31'h0, bias}, 32'h0);
		rc(`AAS_IDX_THR_A_UP, 32'h3FF);
		rc(`AAS_IDX_FLAGS, 32'h0);
		rc(8'h30, 32'h0);
		chk({31'h0, last_err}, 32'h1);
	endtask

	task automatic t_single();
		wr(`AAS_IDX_CTL1, 32'hDE);
		wr(`AAS_IDX_THR_B_UP, 32'h0);
		wr(`AAS_IDX_IRQC, 32'h33);
		wr(`AAS_IDX_CTL2, 32'h22);
		// The write lands at the edge the task returns on; look one edge later
		@(posedge mclk_in);
		chk({31'h0, bias}, 32'h1);
		repeat (1000) @(posedge mclk_in);
		wr(`AAS_IDX_CTL2, 32'h23);
		poll(`AAS_IDX_CTL2, 0, 1'b0);
		data(4'hD, base);
		data(4'hE, base);
		data(4'hF, base);
		rc(8'h18, 32'h0);
		rc(`AAS_IDX_FLAGS, 32'h20);
		rc(`AAS_IDX_IRQC, 32'hF3);
		chk({30'h0, irq_wd, irq_seq}, 32'h2);
		chk({29'h0, irq_lvl}, 32'h3);
		wr(`AAS_IDX_IRQC, 32'hB3);
		rc(`AAS_IDX_FLAGS, 32'h0);
		chk({30'h0, irq_wd, irq_seq}, 32'h1);
		wr(`AAS_IDX_IRQC, 32'hE3);
		repeat (3) @(posedge mclk_in);
		chk({30'h0, irq_wd, irq_seq}, 32'h1);
		wr(`AAS_IDX_IRQC, 32'h73);
		repeat (3) @(posedge mclk_in);
		chk({30'h0, irq_wd, irq_seq}, 32'h2);
		wr(`AAS_IDX_IRQC, 32'h0);
	endtask

	task automatic t_cont();
		int n = 0;
		wr(`AAS_IDX_CTL1, 32'hFE);
		wr(`AAS_IDX_CTL2, 32'h53);
		while (sample !== 1'b1 && n < 300) begin
			@(posedge mclk_in);
			n++;
		end
		n = 0;
		while (sample === 1'b1 && n < 300) begin
			@(posedge mclk_in);
			n++;
		end
		chk(n, 32'd32);
		n = 0;
		while (sample !== 1'b1 && n < 300) begin
			@(posedge mclk_in);
			n++;
		end
		chk(n, 32'd80);
		chk({28'h0, mux_ch}, 32'hF);
		// Analog clock high phase lasts div cycles; start from a low phase
		n = 0;
		while (aclk === 1'b1 && n < 20) begin
			@(posedge mclk_in);
			n++;
		end
		while (aclk !== 1'b1 && n < 20) begin
			@(posedge mclk_in);
			n++;
		end
		n = 0;
		while (aclk === 1'b1 && n < 20) begin
			@(posedge mclk_in);
			n++;
		end
		chk(n, 32'd2);
		poll(`AAS_IDX_IRQC, 7, 1'b1);
		wr(`AAS_IDX_IRQC, 32'h0);
		base = 10'h0C3;
		poll(`AAS_IDX_IRQC, 7, 1'b1);
		data(4'hF, 10'h0C3);
		wr(`AAS_IDX_CTL2, 32'h52);
		rc(`AAS_IDX_CTL2, 32'h52);
		wr(`AAS_IDX_IRQC, 32'h0);
		repeat (300) @(posedge mclk_in);
		rc(`AAS_IDX_IRQC, 32'h0);
	endtask

	task automatic t_trig();
		wr(`AAS_IDX_CTL2, 32'h28);
		pulse(1'b0);
		repeat (8) @(posedge mclk_in);
		rc(`AAS_IDX_CTL2, 32'h28);
		pulse(1'b1);
		repeat (8) @(posedge mclk_in);
		rc(`AAS_IDX_CTL2, 32'h29);
		poll(`AAS_IDX_CTL2, 0, 1'b0);
		wr(`AAS_IDX_CTL2, 32'h26);
		pulse(1'b1);
		repeat (8) @(posedge mclk_in);
		rc(`AAS_IDX_CTL2, 32'h26);
		pulse(1'b0);
		repeat (8) @(posedge mclk_in);
		rc(`AAS_IDX_CTL2, 32'h27);
		pulse(1'b0);
		poll(`AAS_IDX_CTL2, 0, 1'b0);
		repeat (100) @(posedge mclk_in);
		rc(`AAS_IDX_CTL2, 32'h26);
	endtask

	task automatic t_halt();
		wr(`AAS_IDX_CTL2, 32'h02);
		@(posedge mclk_in);
		halt <= 1'b1;
		repeat (3) @(posedge mclk_in);
		chk({31'h0, bias}, 32'h0);
		halt <= 1'b0;
		repeat (3) @(posedge mclk_in);
		// Halt clears the bias bit itself, so it stays off once halt ends
		chk({31'h0, bias}, 32'h0);
		rc(`AAS_IDX_CTL2, 32'h0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_single();
		t_cont();
		t_trig();
		t_halt();
		print_verdict();
	end

	// Whole run needs well under 10000 cycles; this cuts a hang short
	initial begin
		repeat (30000) @(posedge mclk_in);
		num_errors++;
		print_verdict();
	end
endmodule // aas_top_tb_top
